// >>> design/jtsc_regs.vh
// Constants for the test access port state controller
// Overview of operation
// - Sample mode and data on rising test clock; data out changes on falling.
// - Test reset low forces reset state and loads the identify instruction.
// - Reset state clears only controller and instruction register.
// - Five rising edges with mode high reach reset state; stays while high.
// - Reset-state instruction latch conflict resolved: identify code is presented.
// - Idle holds on mode low, goes to select data scan on high.
// - Select data scan: low to capture data, high to select instruction scan.
// - Select instruction scan: low to capture instruction, high to reset.
// - Capture data loads selected register; low to shift, high to exit1.
// - Shift data moves one stage toward output per edge; high exits.
// - Exit1 data: low to pause, high to update; registers hold.
// - Pause data halts shifting; stays while low, high to exit2.
// - Exit2 data: low back to shift, high to update.
// - Update data applies shifted value; low to idle, high to select.
// - Parallel latches hold during capture and shift, load only at update.
// - Capture instruction loads pattern 00001; low to shift, high to exit1.
// - Shift instruction path between input and output, one stage per edge.
// - Exit1 instruction: low to pause, high to update; register holds.
// - Pause instruction halts shifting; stays while low, high to exit2.
// - Exit2 instruction: low back to shift, high to update.
// - Update instruction applies new instruction; low to idle, high to select.
// - Active instruction changes only in update instruction or reset state.
// - Five-bit instruction register; unknown codes act as bypass.
// - Bypass is a single stage, selected by all-ones instruction.
// - Code 01 selects the 32-bit identification register.
// - Data output driven only while shifting, released otherwise.
`ifndef JTSC_REGS_VH
`define JTSC_REGS_VH
`define JTSC_IR_W        5
`define JTSC_IR_CAPTURE  5'h01
`define JTSC_IR_IDCODE   5'h01
`define JTSC_IR_BYPASS   5'h1f
`define JTSC_IR_USER     5'h08
`define JTSC_ID_W        32
`define JTSC_ID_VALUE    32'h00000001
`define JTSC_USER_W      32
`define JTSC_ST_W        16
`endif

// >>> design/jtsc_tap.v
// Test access port state controller sampled on the system clock
`timescale 1ns/100ps
`include "jtsc_regs.vh"
module jtsc_tap #(
  parameter [`JTSC_ID_W-1:0] ID_VALUE = `JTSC_ID_VALUE // Arbitrary identity value
) (
  input  wire                    clk,        // System clock 100 MHz
  input  wire                    nrst,       // Async reset, active low
  input  wire                    tck,        // Test clock pin
  input  wire                    tms,        // Mode select pin
  input  wire                    tdi,        // Serial data in pin
  input  wire                    trst_n,     // Test reset pin, active low
  input  wire [`JTSC_USER_W-1:0] user_cap,   // Capture value of user register
  output reg                     tdo,        // Serial data out
  output reg                     tdo_oe_n,   // Data out enable, low drives
  output reg  [`JTSC_IR_W-1:0]   instr,      // Active instruction
  output reg  [`JTSC_USER_W-1:0] user_upd,   // Parallel latches of user register
  output reg                     user_upd_p, // Pulse when user latches load
  output reg  [`JTSC_ST_W-1:0]   tap_state   // One-hot controller state
);

  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PD  = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PI  = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  localparam [1:0] SEL_BYP  = 2'h0;
  localparam [1:0] SEL_ID   = 2'h1;
  localparam [1:0] SEL_USER = 2'h2;

  // Unimplemented codes fall back to bypass
  function [1:0] sel_of;
    input [`JTSC_IR_W-1:0] code;
    begin
      case (code)
        `JTSC_IR_IDCODE: begin
          sel_of = SEL_ID;
        end
        `JTSC_IR_USER: begin
          sel_of = SEL_USER;
        end
        default: begin
          sel_of = SEL_BYP;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [1:0] trst_s;
  reg       tck_d;

  // Test clock: two stages, a third only for edge detection
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tck_s <= 2'h0;
      tck_d <= 1'b0;
    end else begin
      tck_s <= {tck_s[0], tck};
      tck_d <= tck_s[1];
    end
  end

  // Mode resets high, its idle level, so no spurious move after reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tms_s <= 2'h3;
    end else begin
      tms_s <= {tms_s[0], tms};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdi_s <= 2'h0;
    end else begin
      tdi_s <= {tdi_s[0], tdi};
    end
  end

  // Starts asserted: controller held in reset until the pin is seen high
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trst_s <= 2'h0;
    end else begin
      trst_s <= {trst_s[0], trst_n};
    end
  end
  wire tck_rise = tck_s[1] & ~tck_d;
  wire tck_fall = ~tck_s[1] & tck_d;
  wire tms_v    = tms_s[1];
  wire tdi_v    = tdi_s[1];
  wire treset   = ~trst_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // Controller state
  reg [15:0] next_state;
  always @* begin
    case (tap_state)
      // Reset holds while mode stays high
      S_TLR: begin
        if (tms_v)
          next_state = S_TLR;
        else
          next_state = S_RTI;
      end
      // Idle between scans
      S_RTI: begin
        if (tms_v)
          next_state = S_SDR;
        else
          next_state = S_RTI;
      end
      // Choose data scan or go on to instruction scan
      S_SDR: begin
        if (tms_v)
          next_state = S_SIR;
        else
          next_state = S_CDR;
      end
      // Third high in a row heads for reset
      S_SIR: begin
        if (tms_v)
          next_state = S_TLR;
        else
          next_state = S_CIR;
      end
      S_CDR: begin
        if (tms_v)
          next_state = S_E1D;
        else
          next_state = S_SHD;
      end
      S_SHD: begin
        if (tms_v)
          next_state = S_E1D;
        else
          next_state = S_SHD;
      end
      S_E1D: begin
        if (tms_v)
          next_state = S_UDR;
        else
          next_state = S_PD;
      end
      // Probe may park here while it refills its buffers
      S_PD: begin
        if (tms_v)
          next_state = S_E2D;
        else
          next_state = S_PD;
      end
      S_E2D: begin
        if (tms_v)
          next_state = S_UDR;
        else
          next_state = S_SHD;
      end
      S_UDR: begin
        if (tms_v)
          next_state = S_SDR;
        else
          next_state = S_RTI;
      end
      S_CIR: begin
        if (tms_v)
          next_state = S_E1I;
        else
          next_state = S_SHI;
      end
      S_SHI: begin
        if (tms_v)
          next_state = S_E1I;
        else
          next_state = S_SHI;
      end
      S_E1I: begin
        if (tms_v)
          next_state = S_UIR;
        else
          next_state = S_PI;
      end
      S_PI: begin
        if (tms_v)
          next_state = S_E2I;
        else
          next_state = S_PI;
      end
      S_E2I: begin
        if (tms_v)
          next_state = S_UIR;
        else
          next_state = S_SHI;
      end
      S_UIR: begin
        if (tms_v)
          next_state = S_SDR;
        else
          next_state = S_RTI;
      end
      // Illegal code recovers through reset
      default: begin
        next_state = S_TLR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift paths and latches
  reg [`JTSC_IR_W-1:0]   ir_sh;
  reg [`JTSC_ID_W-1:0]   dr_sh;
  reg                    byp_sh;
  wire [1:0]             sel = sel_of(instr);

  // Controller state register, moved by detected test clock rises or forced to reset state by test reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tap_state <= S_TLR;
    end else if (treset) begin
      tap_state <= S_TLR;
    end else if (tck_rise) begin
      tap_state <= next_state;
    end
  end

  // Reset state touches only controller and instruction; user latches survive
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_sh      <= `JTSC_IR_CAPTURE;
      instr      <= `JTSC_IR_IDCODE;
      dr_sh      <= {`JTSC_ID_W{1'b0}};
      byp_sh     <= 1'b0;
      user_upd   <= {`JTSC_USER_W{1'b0}};
      user_upd_p <= 1'b0;
    end else if (treset) begin
      ir_sh      <= `JTSC_IR_CAPTURE;
      instr      <= `JTSC_IR_IDCODE;
      user_upd_p <= 1'b0;
    end else begin
      user_upd_p <= 1'b0;
      if (tck_rise) begin
        case (tap_state)
          S_TLR: begin
            ir_sh <= `JTSC_IR_CAPTURE;
            instr <= `JTSC_IR_IDCODE;
          end
          S_CDR: begin
            byp_sh <= 1'b0;
            if (sel == SEL_ID)
              dr_sh <= ID_VALUE;
            else
              dr_sh <= user_cap;
          end
          S_SHD: begin
            byp_sh <= tdi_v;
            dr_sh  <= {tdi_v, dr_sh[`JTSC_ID_W-1:1]};
          end
          S_UDR: begin
            if (sel == SEL_USER) begin
              user_upd   <= dr_sh;
              user_upd_p <= 1'b1;
            end
          end
          S_CIR: ir_sh <= `JTSC_IR_CAPTURE;
          S_SHI: ir_sh <= {tdi_v, ir_sh[`JTSC_IR_W-1:1]};
          S_UIR: instr <= ir_sh;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output on falling test clock
  reg next_tdo;
  always @* begin
    if (tap_state == S_SHI) begin
      next_tdo = ir_sh[0];
    end else begin
      case (sel)
        SEL_BYP: begin
          next_tdo = byp_sh;
        end
        default: begin
          next_tdo = dr_sh[0];
        end
      endcase
    end
  end

  // Data bit moves on the falling edge, so it is settled for the probe's rise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo <= 1'b0;
    end else if (!treset && tck_fall) begin
      tdo <= next_tdo;
    end
  end

  // Released outside the two shift states; test reset releases at once
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo_oe_n <= 1'b1;
    end else if (treset) begin
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n <= ~((tap_state == S_SHD) | (tap_state == S_SHI));
    end
  end

endmodule

// >>> tb/jtsc_tap_asserts.sv
// Concurrent checks on the test access port controller ports
`timescale 1ns/100ps
module jtsc_tap_asserts (
  input logic        clk,        // System clock
  input logic        nrst,       // Async reset, low
  input logic        trst_n,     // Test reset, low
  input logic        tdo_oe_n,   // Out enable, low drives
  input logic [4:0]  instr,      // Active instruction
  input logic [31:0] user_upd,   // User latches
  input logic        user_upd_p, // Latch load pulse
  input logic [15:0] tap_state   // One-hot state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_leave_sel_ir; $fell(tap_state[9]); endsequence
  sequence s_ir_entry; tap_state[10] || tap_state[0]; endsequence
  // Synchroniser adds up to three cycles, so five low samples suffice
  a_trst_forces_tlr: assert property (!trst_n [*5] |-> tap_state == 16'h0001 && instr == 5'h01)
    else $error("test reset did not force reset state");
  a_idle_exit: assert property ($fell(tap_state[1]) |-> tap_state[2] || tap_state[0])
    else $error("bad exit from idle");
  a_sel_ir_next: assert property (s_leave_sel_ir |-> s_ir_entry)
    else $error("bad exit from select instruction scan");
  a_cap_ir_next: assert property ($fell(tap_state[10]) |-> |{tap_state[12:11], tap_state[0]})
    else $error("bad exit from capture instruction");
  a_ex2dr_next: assert property ($fell(tap_state[7]) |-> |{tap_state[8], tap_state[4], tap_state[0]})
    else $error("bad exit from second data exit");
  a_instr_fixed: assert property ($changed(instr) |-> $past(tap_state[15]) || $past(tap_state[0]) || tap_state[0])
    else $error("instruction changed outside update or reset");
  a_latch_update: assert property ($changed(user_upd) |-> $past(tap_state[8]))
    else $error("user latches changed outside update");
  a_oe_in_shift: assert property (!tdo_oe_n |-> |{tap_state[12:11], tap_state[5:4], tap_state[0]})
    else $error("data out driven outside shift");
  a_pulse_single: assert property (user_upd_p |=> !user_upd_p)
    else $error("load pulse longer than one cycle");
endmodule

// >>> tb/jtsc_probe.sv
// Debug probe model driving the test clock, mode and data pins
`timescale 1ns/100ps
module jtsc_probe (
  input  logic clk,     // Bench clock
  output logic tck,     // Test clock
  output logic tms,     // Mode select
  output logic tdi,     // Serial data
  input  logic tdo,     // Serial out
  input  logic tdo_oe_n // Out enable, low drives
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Clock stands low between steps; mode and data settle well before the rise
  task step(input logic m, input logic d, output logic o);
    @(negedge clk);
    tms = m;
    tdi = d;
    #50 tck = 1'b1;
    o = tdo_oe_n ? 1'b1 : tdo; // Released line floats high by pull-up
    #62.5 tck = 1'b0;
    #12.5;
  endtask
  task reset5;
    logic x;
    repeat (5) step(1'b1, 1'b0, x);
  endtask
endmodule

// >>> tb/jtsc_tap_tb_top.sv
// Self-checking bench for the test access port controller
`timescale 1ns/100ps
module jtsc_tap_tb_top;
  logic clk = 1'b0;
  logic nrst, trst_n, tck, tms, tdi, tdo, tdo_oe_n, user_upd_p, x;
  logic [31:0] user_cap, user_upd, g;
  logic [4:0]  instr;
  logic [15:0] tap_state;
  int n_errors = 0;
  int checks_done = 0;
  int n_pulse = 0;
  localparam [31:0] ID = 32'h0000_1235; // Arbitrary identity value
  always #5 clk = ~clk;
  always @(negedge clk) if (user_upd_p === 1'b1) n_pulse++;
  jtsc_tap #(.ID_VALUE(ID)) i_dut (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .user_cap(user_cap), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .instr(instr),
    .user_upd(user_upd), .user_upd_p(user_upd_p), .tap_state(tap_state));
  jtsc_probe i_probe (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));
  task chk(input string nm, input [31:0] e, input [31:0] s);
    checks_done++;
    if (e !== s) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Scan from idle back to idle; bit p is followed by a pause if p < n - 1
  task scan(input logic ir, input int n, input [31:0] v, input int p, output [31:0] got);
    got = '0;
    i_probe.step(1'b1, 1'b0, x);
    if (ir) i_probe.step(1'b1, 1'b0, x);
    i_probe.step(1'b0, 1'b0, x);
    i_probe.step(1'b0, 1'b0, x);
    for (int i = 0; i < n; i++) begin
      i_probe.step(i == n - 1 || i == p, v[i], got[i]);
      if (i == p && i != n - 1) begin
        repeat (3) i_probe.step(1'b0, 1'b1, x);
        i_probe.step(1'b1, 1'b0, x);
        i_probe.step(1'b0, 1'b0, x);
      end
    end
    i_probe.step(1'b1, 1'b0, x);
    i_probe.step(1'b0, 1'b0, x);
  endtask
  task t_user;
    scan(1'b1, 5, 32'h08, 1, g);
    chk("ir capture", 32'h01, g);
    chk("instr", 5'h08, instr);
    scan(1'b0, 32, 32'h1234abcd, 9, g);
    chk("user capture", user_cap, g);
    chk("user latch", 32'h1234abcd, user_upd);
    chk("load pulses", 32'h1, n_pulse);
  endtask
  task t_trst;
    @(negedge clk) trst_n = 1'b0;
    repeat (5) @(negedge clk);
    chk("trst state", 16'h0001, tap_state);
    chk("trst instr", 5'h01, instr);
    chk("latch kept", 32'h1234abcd, user_upd);
    trst_n = 1'b1;
    repeat (3) @(negedge clk);
    i_probe.step(1'b0, 1'b0, x);
    scan(1'b0, 32, 32'hffff0000, 31, g);
    chk("id", ID, g);
  endtask
  task t_bypass;
    logic [4:0] codes [2];
    codes = '{5'h1f, 5'h0a};
    for (int k = 0; k < 2; k++) begin
      scan(1'b1, 5, {27'h0, codes[k]}, 5, g);
      scan(1'b0, 8, 32'h96, 8, g);
      chk("bypass", 32'h2c, g);
    end
    i_probe.reset5;
    chk("tms reset", 16'h0001, tap_state);
    chk("reset instr", 5'h01, instr);
    i_probe.step(1'b1, 1'b0, x);
    chk("stay reset", 16'h0001, tap_state);
  endtask
  initial begin
    nrst = 1'b0;
    trst_n = 1'b1;
    user_cap = 32'ha5c30f96;
    repeat (16) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset instr", 5'h01, instr);
    chk("oe idle", 1'b1, tdo_oe_n);
    i_probe.step(1'b0, 1'b0, x);
    chk("idle", 16'h0002, tap_state);
    t_user;
    t_trst;
    t_bypass;
    chk("no extra load", 32'h1, n_pulse);
    report_and_stop;
  end
  initial begin
    #300000;
    chk("time limit", 32'h0, 32'h1);
    report_and_stop;
  end
endmodule
bind jtsc_tap jtsc_tap_asserts i_chk (.clk(clk), .nrst(nrst), .trst_n(trst_n),
  .tdo_oe_n(tdo_oe_n), .instr(instr), .user_upd(user_upd), .user_upd_p(user_upd_p),
  .tap_state(tap_state));
